//--- core/prs_paged_regs.sv
// Paged register and data buffer space behind the serial host decoder.
// Assumes all inputs are synchronous to clk; the decoder issues one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"

module prs_paged_regs
   import prs_pkg::*;
#(
   parameter logic [7:0] UNLOCK_KEY = `PRS_UNLOCK_KEY, // Arbitrary value
   parameter int         EVT_W      = 8
) (
   input  wire logic                      clk,          // 40 MHz clock
   input  wire logic                      srst,         // Sync reset, active high
   input  wire prs_req_t                  req,          // Host register strobe
   output logic [`PRS_DATA_W-1:0]         rd_data,      // Read data, registered
   output logic                           rd_valid,     // Read data valid pulse
   output logic [7:0]                     page,         // Active page
   output logic                           test_active,  // Test page mapped
   input  wire prs_rx_byte_t              rx_byte,      // Receiver C/U byte
   input  wire logic                      rx_block_end, // Receiver block done
   input  wire logic [`PRS_BUF_IDX_W-1:0] tx_idx,       // Transmitter byte index
   output logic [`PRS_DATA_W-1:0]         tx_data,      // Transmitter C/U byte
   input  wire logic [EVT_W-1:0]          evt,          // Event pulses
   output logic                           irq           // Interrupt, active high
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0]       ctrl [`PRS_CTRL_FIRST:`PRS_CTRL_LAST];
   logic [7:0]       rx_stage [0:`PRS_BUF_BYTES-1];
   logic [7:0]       rx_buf   [0:`PRS_BUF_BYTES-1];
   logic [7:0]       tx_buf   [0:`PRS_BUF_BYTES-1];
   // Status and enable sit apart from the plain bytes so a read can clear
   logic [EVT_W-1:0] status;
   logic [EVT_W-1:0] enable;
   logic             unlocked;

   ////////////////////////////////////////////////////////////////////////////
   // Page decode
   wire        hit_page  = (req.addr == `PRS_PAGE_SEL_ADDR);
   wire        pg_ctrl   = (page == `PRS_PAGE_CTRL);
   wire        pg_rx     = (page == `PRS_PAGE_RX);
   wire        pg_tx     = (page == `PRS_PAGE_TX);

   ////////////////////////////////////////////////////////////////////////////
   // Address windows: buffer offsets 0x00-0x2F and 0x40-0x6F fold onto one index
   wire        in_ctrl   = (req.addr >= `PRS_CTRL_FIRST) && (req.addr <= `PRS_CTRL_LAST);
   wire        hit_stat  = pg_ctrl && (req.addr == `PRS_STATUS_ADDR);
   wire        hit_en    = pg_ctrl && (req.addr == `PRS_ENABLE_ADDR);
   wire        hit_key   = pg_ctrl && (req.addr == `PRS_UNLOCK_ADDR);
   wire        in_cs     = (req.addr <= `PRS_CS_LAST);
   wire        in_user   = (req.addr >= `PRS_USER_BASE) && (req.addr <= `PRS_USER_LAST);
   wire        in_buf    = in_cs || in_user;
   wire [6:0]  user_off  = req.addr - `PRS_USER_BASE;
   wire [6:0]  buf_idx   = in_cs ? req.addr : user_off + 7'(`PRS_HALF_BYTES);
   wire        rx_in_rng = (rx_byte.idx < 7'(`PRS_BUF_BYTES));
   wire        tx_in_rng = (tx_idx < 7'(`PRS_BUF_BYTES));

   ////////////////////////////////////////////////////////////////////////////
   // Write and read qualifiers
   wire [7:0]  new_page  = req.wdata;
   wire        page_ok   = (new_page <= `PRS_PAGE_TX)
                           || ((new_page == `PRS_PAGE_TEST) && unlocked);
   wire        wr_page   = req.wr && hit_page && page_ok;
   wire        wr_ctrl   = req.wr && pg_ctrl && in_ctrl && !hit_stat && !hit_en;
   wire        wr_tx     = req.wr && pg_tx && in_buf && !hit_page;
   wire        wr_key    = req.wr && hit_key;
   wire        key_match = (req.wdata == UNLOCK_KEY);
   wire        wr_en     = req.wr && hit_en;
   wire        rd_stat   = req.rd && hit_stat;
   wire [EVT_W-1:0] stat_clr = rd_stat ? status : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer
   // Page select is tested first so it answers on every page
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = `PRS_ZERO_BYTE;
      if (hit_page) begin
         rd_mux = page;
      end else if (hit_stat) begin
         rd_mux = 8'(status);
      end else if (hit_en) begin
         rd_mux = 8'(enable);
      end else if (pg_ctrl && in_ctrl) begin
         rd_mux = ctrl[req.addr];
      end else if (pg_rx && in_buf) begin
         rd_mux = rx_buf[buf_idx];
      end else if (pg_tx && in_buf) begin
         rd_mux = tx_buf[buf_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs decoded straight from registers
   assign test_active = (page == `PRS_PAGE_TEST);
   assign irq         = |(status & enable);

   ////////////////////////////////////////////////////////////////////////////
   // Page select: a refused value leaves the current page in place
   always_ff @(posedge clk) begin
      if (srst) begin
         page <= `PRS_PAGE_RESET;
      end else if (wr_page) begin
         page <= new_page;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test page lock: any other value written to the key location relocks
   always_ff @(posedge clk) begin
      if (srst) begin
         unlocked <= 1'b0;
      end else if (wr_key) begin
         unlocked <= key_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read return: valid pulses once per read, data holds until the next read
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= `PRS_ZERO_BYTE;
      end else if (req.rd) begin
         rd_data <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status: an event in the clearing read's cycle survives
   always_ff @(posedge clk) begin
      if (srst) begin
         status <= '0;
      end else begin
         status <= (status & ~stat_clr) | evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enables
   always_ff @(posedge clk) begin
      if (srst) begin
         enable <= '0;
      end else if (wr_en) begin
         enable <= req.wdata[EVT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = `PRS_CTRL_FIRST; i <= `PRS_CTRL_LAST; i++) begin
            ctrl[i] <= `PRS_ZERO_BYTE;
         end
      end else if (wr_ctrl) begin
         ctrl[req.addr] <= req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver staging: bytes may arrive in any order within a block
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < `PRS_BUF_BYTES; i++) begin
            rx_stage[i] <= `PRS_ZERO_BYTE;
         end
      end else if (rx_byte.valid && rx_in_rng) begin
         rx_stage[rx_byte.idx] <= rx_byte.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver buffers: the staged block is published whole, so the host
   // never reads a mix of two blocks
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < `PRS_BUF_BYTES; i++) begin
            rx_buf[i] <= `PRS_ZERO_BYTE;
         end
      end else if (rx_block_end) begin
         for (int i = 0; i < `PRS_BUF_BYTES; i++) begin
            rx_buf[i] <= rx_stage[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter buffers: written by the host, read back unchanged
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < `PRS_BUF_BYTES; i++) begin
            tx_buf[i] <= `PRS_ZERO_BYTE;
         end
      end else if (wr_tx) begin
         tx_buf[buf_idx] <= req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter byte fetch: one cycle after the index is sampled
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_data <= `PRS_ZERO_BYTE;
      end else begin
         tx_data <= tx_in_rng ? tx_buf[tx_idx] : `PRS_ZERO_BYTE;
      end
   end

endmodule : prs_paged_regs

`default_nettype wire

//--- core/prs_params.svh
// Constants for the paged register space: offsets, field positions, reset values.
// Assumes a serial host decoder in front that delivers byte-wide register strobes.
// Contract
// - The page select register answers at 0x7F on every page, so the page can always be changed.
// - Page value 00 maps control and status, 01 the receiver buffers, 02 the transmitter buffers.
// - The test page 03 is reachable only after a private unlock code has been given.
// - Page 1 shows the channel status and user bytes of the last completely received block.
// - The receiver buffers are readable by the host through the register port.
// - Host writes to page 2 become the channel status and user bytes sent by the transmitter.
// - Reads of page 2 return the stored transmitter bytes for verification.
// - On page 0, address 0x00 and 0x34 through 0x7D are reserved with no function; 0x7E takes the unlock code.
// - Page 0 event status bits raise the interrupt output only when their enable is set.
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

`define PRS_ADDR_W        7
`define PRS_DATA_W        8
`define PRS_PAGE_SEL_ADDR 7'h7F
`define PRS_PAGE_CTRL     8'h00
`define PRS_PAGE_RX       8'h01
`define PRS_PAGE_TX       8'h02
`define PRS_PAGE_TEST     8'h03
`define PRS_PAGE_RESET    8'h00
`define PRS_CTRL_FIRST    7'h01
`define PRS_CTRL_LAST     7'h33
`define PRS_STATUS_ADDR   7'h30
`define PRS_ENABLE_ADDR   7'h31
`define PRS_UNLOCK_ADDR   7'h7E
`define PRS_CS_BASE       7'h00
`define PRS_CS_LAST       7'h2F
`define PRS_USER_BASE     7'h40
`define PRS_USER_LAST     7'h6F
`define PRS_HALF_BYTES    48
`define PRS_BUF_BYTES     96
`define PRS_BUF_IDX_W     7
`define PRS_ZERO_BYTE     8'h00
`define PRS_UNLOCK_KEY    8'hA5

`endif

//--- core/prs_pkg.sv
// Types shared by the paged register space.
// Assumes prs_params.svh is on the include path.
`include "prs_params.svh"

package prs_pkg;

   typedef struct packed {
      logic                      wr;    // Write strobe, one cycle
      logic                      rd;    // Read strobe, one cycle
      logic [`PRS_ADDR_W-1:0]    addr;  // Register address within page
      logic [`PRS_DATA_W-1:0]    wdata; // Write data
   } prs_req_t;

   typedef struct packed {
      logic                      valid; // Byte strobe from receiver
      logic [`PRS_BUF_IDX_W-1:0] idx;   // 0..47 channel status, 48..95 user
      logic [`PRS_DATA_W-1:0]    data;  // Captured byte
   } prs_rx_byte_t;

endpackage : prs_pkg

//--- dv/paged_register_space_tb.sv
// Bench for the paged register space.
// Assumes prs_host drives the register port; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module paged_register_space_tb
   import prs_pkg::*;
();
   logic         clk = 1'b0, srst = 1'b1, rx_end = 1'b0, rd_valid, test_active, irq, ok;
   logic [7:0]   rd_data, page, tx_data, d, evt = 8'h00;
   logic [6:0]   tx_idx = 7'h00;
   prs_req_t     req;
   prs_rx_byte_t rx = '0;
   int           fails = 0, compares = 0;
   always #12.5 clk = ~clk;
   prs_paged_regs prs_paged_regs_i (.clk(clk), .srst(srst), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .page(page), .test_active(test_active), .rx_byte(rx),
      .rx_block_end(rx_end), .tx_idx(tx_idx), .tx_data(tx_data), .evt(evt), .irq(irq));
   prs_host prs_host_i (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .req(req));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      prs_host_i.rd(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp);
   endtask : rchk
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      wt(8);
      srst = 1'b0;
      chk(page, 8'h00);
      prs_host_i.wr(7'h05, 8'h3C);
      rchk(7'h05, 8'h3C);
      rchk(7'h00, 8'h00);
      prs_host_i.wr(7'h34, 8'h77);
      rchk(7'h34, 8'h00);
      prs_host_i.wr(7'h7F, 8'h03);
      rchk(7'h7F, 8'h00);
      prs_host_i.wr(7'h7E, 8'hA5);
      prs_host_i.wr(7'h7F, 8'h03);
      chk({7'h00, test_active}, 8'h01);
      rchk(7'h05, 8'h00);
      rchk(7'h7F, 8'h03);
      prs_host_i.wr(7'h7F, 8'h04);
      chk(page, 8'h03);
      prs_host_i.wr(7'h7F, 8'h02);
      prs_host_i.wr(7'h45, 8'h5B);
      rchk(7'h45, 8'h5B);
      tx_idx = 7'd53;
      wt(1);
      chk(tx_data, 8'h5B);
      prs_host_i.wr(7'h7F, 8'h01);
      rx = '{1'b1, 7'd5, 8'h11};
      wt(1);
      rx = '{1'b1, 7'd53, 8'h22};
      wt(1);
      rx = '{1'b1, 7'd6, 8'h33};
      rchk(7'h05, 8'h00);
      rx_end = 1'b1;
      wt(1);
      rx_end = 1'b0;
      rx = '0;
      rchk(7'h05, 8'h11);
      rchk(7'h45, 8'h22);
      srst = 1'b1;
      wt(1);
      srst = 1'b0;
      chk(page, 8'h00);
      prs_host_i.wr(7'h31, 8'h01);
      for (int i = 2; i > 0; i--) begin
         evt = 8'(i);
         wt(1);
         evt = 8'h00;
         wt(1);
         chk({7'h00, irq}, {7'h00, |(8'(i) & 8'h01)});
         rchk(7'h30, 8'(i));
      end
      chk({7'h00, irq}, 8'h00);
      evt = 8'h01;
      rchk(7'h30, 8'h01);
      evt = 8'h00;
      chk({7'h00, irq}, 8'h01);
      rchk(7'h30, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wrap_up();
   end
endmodule : paged_register_space_tb
`default_nettype wire

//--- dv/prs_host.sv
// Host model issuing register strobes.
// Assumes the bench calls wr and rd by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module prs_host
   import prs_pkg::*;
(
   input  wire logic       clk,      // Clock
   input  wire logic       rd_valid, // Read answer strobe
   input  wire logic [7:0] rd_data,  // Read answer byte
   output var  prs_req_t   req       // Register strobe
);
   initial req = '0;
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, 8'hFF};
      ok = rd_valid;
      d = rd_data;
   endtask : rd
endmodule : prs_host
`default_nettype wire

//--- dv/prs_paged_regs_properties.sv
// Port checker for the paged register space.
// Assumes it is bound onto prs_paged_regs.
`timescale 1ns/1ps
`default_nettype none
module prs_paged_regs_properties
   import prs_pkg::*;
(
   input wire logic       clk,         // Clock
   input wire logic       srst,        // Sync reset
   input wire prs_req_t   req,         // Host strobe
   input wire logic [7:0] rd_data,     // Read data
   input wire logic       rd_valid,    // Read valid
   input wire logic [7:0] page,        // Active page
   input wire logic       test_active, // Test page flag
   input wire logic       irq          // Interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire pg_wr = req.wr && req.addr == 7'h7F;
   wire rsvd = req.addr == 7'h00 || (req.addr >= 7'h34 && req.addr <= 7'h7D);
   property p_rdv; req.rd |=> rd_valid; endproperty
   property p_hold; !rd_valid && !$past(srst) |-> $stable(rd_data); endproperty
   property p_pg_wr; pg_wr && req.wdata <= 8'h02 |=> page == $past(req.wdata); endproperty
   property p_pg_bad; pg_wr && req.wdata > 8'h03 |=> $stable(page); endproperty
   property p_pg_keep; !pg_wr |=> $stable(page); endproperty
   property p_test; test_active == (page == 8'h03); endproperty
   property p_rst; $fell(srst) |-> page == 8'h00 && !irq && !rd_valid; endproperty
   property p_rsvd; req.rd && page == 8'h00 && rsvd |=> rd_data == 8'h00; endproperty
   a_rdv: assert property (p_rdv) else $error("read not answered");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_pg_wr: assert property (p_pg_wr) else $error("page not taken");
   a_pg_bad: assert property (p_pg_bad) else $error("bad page taken");
   a_pg_keep: assert property (p_pg_keep) else $error("page moved");
   a_test: assert property (p_test) else $error("test flag wrong");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero");
   cover property (pg_wr && req.wdata == 8'h02);
   cover property (test_active);
   cover property (irq);
endmodule : prs_paged_regs_properties
bind prs_paged_regs prs_paged_regs_properties prs_paged_regs_properties_i (.clk(clk),
   .srst(srst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .page(page),
   .test_active(test_active), .irq(irq));
`default_nettype wire
